// >>> hdl/card_attr_decoder.sv
// Card end: decodes socket strobes into standby, common memory, CIS and the
// configuration registers, and holds the option register.
// Assumes socket pins already synchronous to i_clock; memory user answers in time.
// Operation
// - Config block at attribute address 200h
// - Attribute access byte-wide, even, low lane
// - A2-A1 select option, status, pin, socket
// - Write strobe updates, read strobe returns register
// - CE1 alone: byte access low lane
// - CE2 alone: byte access high lane
// - Both enables: word access, A0 low
// - Attribute low region read returns CIS bytes
// - Writes to CIS region are ignored
// - Odd CE1-only or CE2-only attribute access invalid
// - Word attribute: even byte low lane only
// - Option: soft reset, irq mode, index
// - Soft reset bit holds card in reset
// - Host pulses soft reset for minimum width
// - Clearing soft reset leaves card unconfigured
// - Power-up and hardware reset clear soft reset
// - Soft reset counts as hard reset
// - Irq mode one level, zero pulse
// - Reset clears configuration index to zero
// - Host writes reserved index bits as zero
// - Index 0 memory, 1-3 I/O mappings
module card_attr_decoder
    import card_attr_pkg::*;
(
    // Clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_rst,
    // Socket
    card_socket_if.card_end   bus,
    // Common memory user port
    output logic              o_mem_rd,
    output logic              o_mem_wr,
    output logic [10:0]       o_mem_addr,
    output logic [1:0]        o_mem_lane,
    output logic [15:0]       o_mem_wdata,
    input  wire logic [15:0]  i_mem_rdata,
    // CIS user port
    output logic              o_cis_rd,
    input  wire logic [7:0]   i_cis_rdata,
    // Configuration state
    output logic              o_card_reset,
    output logic              o_hard_reset,
    output logic              o_irq_level,
    output logic [5:0]        o_config_index,
    output map_mode_type      o_map_mode
);

    typedef struct packed {
        logic [7:0]   option;
        logic [7:0]   status;
        logic [7:0]   pinrep;
        logic [7:0]   socket;
        logic         wr_pend;
        logic         wr_cfg;
        logic [1:0]   wr_idx;
        logic [15:0]  dout;
        logic         oe_lo;
        logic         oe_hi;
        logic         mem_rd;
        logic         mem_wr;
        logic         cis_rd;
        logic [10:0]  addr;
        logic [1:0]   lane;
        logic [15:0]  wdata;
        logic         card_reset;
        map_mode_type map;
    } card_state_type;

    card_state_type state_ff;
    card_state_type nxt_state;

    // Pin decode
    logic       ce_lo;
    logic       ce_hi;
    logic       attr;
    logic       rd;
    logic       wr;
    logic       attr_ok;
    logic       cfg_hit;
    logic       cis_hit;
    logic       mem_hit;
    logic [1:0] idx;

    // Register readback by index
    function automatic logic [7:0] reg_read(input card_state_type s, input logic [1:0] i);
        if (i == IDX_OPTION) begin
            reg_read = s.option;
        end else if (i == IDX_STATUS) begin
            reg_read = s.status;
        end else if (i == IDX_PINREP) begin
            reg_read = s.pinrep;
        end else begin
            reg_read = s.socket;
        end
    endfunction

    // Strobe and space decode straight from the socket pins
    always_comb begin
        ce_lo   = !bus.ce1_n;
        ce_hi   = !bus.ce2_n;
        attr    = !bus.reg_n;
        rd      = !bus.oe_n && bus.we_n;
        wr      = bus.oe_n && !bus.we_n;
        attr_ok = attr && ce_lo && (ce_hi || !bus.addr[0]);
        cfg_hit = attr_ok && bus.addr[10:9] == CFG_BASE_ADDR[10:9]
                  && bus.addr[8:3] == CFG_BASE_ADDR[8:3];
        idx     = bus.addr[2:1];
        cis_hit = attr_ok && bus.addr[10:9] == 2'b00;
        mem_hit = !attr && (ce_lo || ce_hi) && !(ce_lo && ce_hi && bus.addr[0]);
    end

    // Next-state: bus answers, deferred writes, reset handling
    always_comb begin
        nxt_state        = state_ff;
        nxt_state.mem_wr = 1'b0;
        nxt_state.mem_rd = 1'b0;
        nxt_state.cis_rd = 1'b0;
        nxt_state.oe_lo  = 1'b0;
        nxt_state.oe_hi  = 1'b0;

        // Reads: one cycle from strobe to data; idle bus stays released
        if (rd && (ce_lo || ce_hi)) begin
            if (cfg_hit) begin
                nxt_state.dout  = {8'h00, reg_read(state_ff, idx)};
                nxt_state.oe_lo = 1'b1;
            end else if (cis_hit) begin
                nxt_state.cis_rd = 1'b1;
                nxt_state.addr   = bus.addr;
                nxt_state.dout   = {8'h00, i_cis_rdata};
                nxt_state.oe_lo  = 1'b1;
            end else if (mem_hit && !state_ff.card_reset) begin
                nxt_state.mem_rd = 1'b1;
                nxt_state.addr   = bus.addr;
                nxt_state.lane   = {ce_hi, ce_lo};
                nxt_state.dout   = i_mem_rdata;
                nxt_state.oe_lo  = ce_lo;
                nxt_state.oe_hi  = ce_hi;
            end
        end

        // Writes: capture while strobe is low, commit on its rising edge
        if (wr && cfg_hit) begin
            nxt_state.wr_pend = 1'b1;
            nxt_state.wr_cfg  = 1'b1;
            nxt_state.wr_idx  = idx;
            nxt_state.wdata   = {8'h00, bus.data[7:0]};
        end else if (wr && mem_hit && !state_ff.card_reset) begin
            nxt_state.wr_pend = 1'b1;
            nxt_state.wr_cfg  = 1'b0;
            nxt_state.addr    = bus.addr;
            nxt_state.lane    = {ce_hi, ce_lo};
            nxt_state.wdata   = bus.data;
        end else if (bus.we_n && state_ff.wr_pend) begin
            nxt_state.wr_pend = 1'b0;
            if (state_ff.wr_cfg) begin
                if (state_ff.wr_idx == IDX_OPTION) begin
                    nxt_state.option = state_ff.wdata[7:0];
                end else if (state_ff.wr_idx == IDX_STATUS) begin
                    nxt_state.status = state_ff.wdata[7:0] & STATUS_WMASK;
                end else if (state_ff.wr_idx == IDX_PINREP) begin
                    nxt_state.pinrep = state_ff.wdata[7:0] & PINREP_WMASK;
                end else begin
                    nxt_state.socket = state_ff.wdata[7:0] & SOCKET_WMASK;
                end
            end else begin
                nxt_state.mem_wr = 1'b1;
            end
        end
        // CIS region writes fall through every branch and change nothing

        // Soft reset holds all but its own bit at reset values
        if (nxt_state.option[CONFIG_SOFT_RESET_BIT] || state_ff.option[CONFIG_SOFT_RESET_BIT]) begin
            nxt_state.option = nxt_state.option & (8'h01 << CONFIG_SOFT_RESET_BIT);
            nxt_state.status = STATUS_RESET;
            nxt_state.pinrep = PINREP_RESET;
            nxt_state.socket = SOCKET_RESET;
            nxt_state.mem_wr = 1'b0;
        end
        nxt_state.card_reset = nxt_state.option[CONFIG_SOFT_RESET_BIT];
        nxt_state.map        = decode_map(nxt_state.option[CFG_IDX_MSB:0]);

        // Power-up or hardware reset pin clears all state, soft reset bit too, but sets card_reset and map to memory
        if (i_rst || bus.card_reset) begin
            nxt_state            = '0;
            nxt_state.option     = OPTION_RESET;
            nxt_state.status     = STATUS_RESET;
            nxt_state.pinrep     = PINREP_RESET;
            nxt_state.socket     = SOCKET_RESET;
            nxt_state.card_reset = 1'b1;
            nxt_state.map        = MAP_MEMORY;
        end
    end

    // State register
    always_ff @(posedge i_clock) begin
        state_ff <= nxt_state;
    end

    // Socket data drivers
    assign bus.card_d       = state_ff.dout;
    assign bus.card_d_oe_lo = state_ff.oe_lo && rd && (ce_lo || ce_hi);
    assign bus.card_d_oe_hi = state_ff.oe_hi && rd && (ce_lo || ce_hi);

    // User side
    assign o_mem_rd       = state_ff.mem_rd;
    assign o_mem_wr       = state_ff.mem_wr;
    assign o_mem_addr     = state_ff.addr;
    assign o_mem_lane     = state_ff.lane;
    assign o_mem_wdata    = state_ff.wdata;
    assign o_cis_rd       = state_ff.cis_rd;
    assign o_card_reset   = state_ff.card_reset;
    assign o_hard_reset   = state_ff.card_reset;
    assign o_irq_level    = state_ff.option[IRQ_LEVEL_BIT];
    assign o_config_index = state_ff.option[CFG_IDX_MSB:0];
    assign o_map_mode     = state_ff.map;

endmodule // card_attr_decoder

// >>> hdl/card_attr_pkg.sv
// Shared constants and types for the card attribute-space decoder pair.
// Assumes a single 100 MHz clock and synchronous active-high reset everywhere.
package card_attr_pkg;

    // Bus geometry
    localparam int ADDR_W = 11;
    localparam int DATA_W = 16;

    // Configuration block base and register indices (address bits A2-A1)
    localparam logic [10:0] CFG_BASE_ADDR = 11'h200;
    localparam logic [1:0]  IDX_OPTION    = 2'h0;
    localparam logic [1:0]  IDX_STATUS    = 2'h1;
    localparam logic [1:0]  IDX_PINREP    = 2'h2;
    localparam logic [1:0]  IDX_SOCKET    = 2'h3;

    // Option register fields
    localparam int CONFIG_SOFT_RESET_BIT    = 7;
    localparam int IRQ_LEVEL_BIT = 6;
    localparam int CFG_IDX_MSB   = 5;

    // Reset values and writable masks
    localparam logic [7:0] OPTION_RESET  = 8'h00;
    localparam logic [7:0] STATUS_RESET  = 8'h00;
    localparam logic [7:0] PINREP_RESET  = 8'h00;
    localparam logic [7:0] SOCKET_RESET  = 8'h00;
    localparam logic [7:0] STATUS_WMASK  = 8'h64;
    localparam logic [7:0] PINREP_WMASK  = 8'h30;
    localparam logic [7:0] SOCKET_WMASK  = 8'h10;
    localparam logic [7:0] CFG_RSVD_MASK = 8'h30;

    // Timing, in ns and in 10 ns clock cycles (least times round up)
    localparam int CLK_PERIOD_NS    = 10;
    localparam int SETUP_NS         = 20;
    localparam int STROBE_NS        = 40;
    localparam int RESET_WIDTH_NS   = 1000;
    localparam int SETUP_CYCLES     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYCLES    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_CYCLES     = (RESET_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Card address mapping chosen by the configuration index
    typedef enum logic [3:0] {
        MAP_MEMORY       = 4'b0001,
        MAP_IO_ANY       = 4'b0010,
        MAP_IO_PRIMARY   = 4'b0100,
        MAP_IO_SECONDARY = 4'b1000
    } map_mode_type;

    // Index to mapping; vendor-defined codes fall back to memory mapping
    function automatic map_mode_type decode_map(input logic [5:0] idx);
        case (idx)
            6'h01:   decode_map = MAP_IO_ANY;
            6'h02:   decode_map = MAP_IO_PRIMARY;
            6'h03:   decode_map = MAP_IO_SECONDARY;
            default: decode_map = MAP_MEMORY;
        endcase
    endfunction

endpackage

// >>> hdl/card_socket_if.sv
// Card socket pins between the host controller and the card.
// Each end drives its own data copy and enables; the wire level is resolved here.
interface card_socket_if;
    logic        ce1_n;
    logic        ce2_n;
    logic        reg_n;
    logic        oe_n;
    logic        we_n;
    logic [10:0] addr;
    logic        card_reset;
    logic [15:0] host_d;
    logic        host_d_oe;
    logic [15:0] card_d;
    logic        card_d_oe_lo;
    logic        card_d_oe_hi;
    wire  [15:0] data;

    // Per-lane resolution; a lane nobody drives reads as pulled-up ones
    assign data[7:0]  = card_d_oe_lo ? card_d[7:0]  : (host_d_oe ? host_d[7:0]  : 8'hFF);
    assign data[15:8] = card_d_oe_hi ? card_d[15:8] : (host_d_oe ? host_d[15:8] : 8'hFF);

    modport card_end (
        input  ce1_n, ce2_n, reg_n, oe_n, we_n, addr, card_reset, data,
        output card_d, card_d_oe_lo, card_d_oe_hi
    );
    modport host_end (
        output ce1_n, ce2_n, reg_n, oe_n, we_n, addr, card_reset, host_d, host_d_oe,
        input  data
    );
endinterface

// >>> hdl/card_socket_host.sv
// Host end: runs one socket cycle per command and the soft reset sequence.
// Assumes the card answers reads within one cycle of the read strobe.
module card_socket_host
    import card_attr_pkg::*;
(
    // Clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_rst,
    // Socket
    card_socket_if.host_end   bus,
    // Command port
    input  wire logic         i_req,
    input  wire logic         i_write,
    input  wire logic         i_attr,
    input  wire logic         i_word,
    input  wire logic         i_hi_lane,
    input  wire logic [10:0]  i_addr,
    input  wire logic [15:0]  i_wdata,
    input  wire logic         i_soft_reset,
    input  wire logic         i_hw_reset,
    output logic              o_ready,
    output logic              o_done,
    output logic [15:0]       o_rdata
);

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_SETUP  = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_WAIT   = 4'b1000
    } host_state_type;

    typedef struct packed {
        host_state_type st;
        logic [7:0]     cnt;
        logic [1:0]     sr_phase;
        logic           write;
        logic           ce1_n;
        logic           ce2_n;
        logic           reg_n;
        logic           oe_n;
        logic           we_n;
        logic [10:0]    addr;
        logic [15:0]    wdata;
        logic [15:0]    rdata;
        logic           done;
        logic           hw_reset;
    } host_reg_type;

    host_reg_type s_ff;
    host_reg_type nxt_s;

    // Sequencer
    always_comb begin
        nxt_s          = s_ff;
        nxt_s.done     = 1'b0;
        nxt_s.hw_reset = i_hw_reset;
        case (s_ff.st)
            ST_IDLE: begin
                nxt_s.cnt = 8'h00;
                if (i_soft_reset || s_ff.sr_phase == 2'd2) begin
                    // Soft reset: set bit, hold, then clear it again
                    nxt_s.st       = ST_SETUP;
                    nxt_s.write    = 1'b1;
                    nxt_s.reg_n    = 1'b0;
                    nxt_s.ce1_n    = 1'b0;
                    nxt_s.ce2_n    = 1'b1;
                    nxt_s.addr     = CFG_BASE_ADDR;
                    nxt_s.wdata    = (s_ff.sr_phase == 2'd2) ? 16'h0000 : 16'h0080;
                    nxt_s.sr_phase = (s_ff.sr_phase == 2'd2) ? 2'd3 : 2'd1;
                end else if (i_req) begin
                    nxt_s.st    = ST_SETUP;
                    nxt_s.write = i_write;
                    nxt_s.reg_n = !i_attr;
                    nxt_s.addr  = i_addr;
                    nxt_s.wdata = i_wdata;
                    if (i_attr) begin
                        nxt_s.ce1_n   = 1'b0;
                        nxt_s.ce2_n   = 1'b1;
                        nxt_s.addr[0] = 1'b0;
                        if (i_addr[10:1] == CFG_BASE_ADDR[10:1]) begin
                            nxt_s.wdata[7:0] = i_wdata[7:0] & ~CFG_RSVD_MASK;
                        end
                    end else if (i_word) begin
                        nxt_s.ce1_n   = 1'b0;
                        nxt_s.ce2_n   = 1'b0;
                        nxt_s.addr[0] = 1'b0;
                    end else begin
                        nxt_s.ce1_n = i_hi_lane;
                        nxt_s.ce2_n = !i_hi_lane;
                    end
                end
            end
            ST_SETUP: begin
                nxt_s.cnt = s_ff.cnt + 8'h01;
                if (s_ff.cnt == 8'(SETUP_CYCLES - 1)) begin
                    nxt_s.st   = ST_STROBE;
                    nxt_s.cnt  = 8'h00;
                    nxt_s.oe_n = s_ff.write;
                    nxt_s.we_n = !s_ff.write;
                end
            end
            ST_STROBE: begin
                nxt_s.cnt = s_ff.cnt + 8'h01;
                if (s_ff.cnt == 8'(STROBE_CYCLES - 1)) begin
                    nxt_s.rdata = bus.data;
                    nxt_s.oe_n  = 1'b1;
                    nxt_s.we_n  = 1'b1;
                    nxt_s.cnt   = 8'h00;
                    nxt_s.st    = (s_ff.sr_phase == 2'd1) ? ST_WAIT : ST_IDLE;
                    nxt_s.done  = (s_ff.sr_phase == 2'd0);
                    if (s_ff.sr_phase == 2'd3) begin
                        nxt_s.sr_phase = 2'd0;
                        nxt_s.done     = 1'b1;
                    end
                    nxt_s.ce1_n = 1'b1;
                    nxt_s.ce2_n = 1'b1;
                    nxt_s.reg_n = 1'b1;
                end
            end
            ST_WAIT: begin
                // Minimum reset pulse width before clearing the bit
                nxt_s.cnt = s_ff.cnt + 8'h01;
                if (s_ff.cnt == 8'(RESET_CYCLES - 1)) begin
                    nxt_s.st       = ST_IDLE;
                    nxt_s.sr_phase = 2'd2;
                end
            end
            default: nxt_s.st = ST_IDLE;
        endcase
        if (i_rst) begin
            nxt_s          = '0;
            nxt_s.st       = ST_IDLE;
            nxt_s.ce1_n    = 1'b1;
            nxt_s.ce2_n    = 1'b1;
            nxt_s.reg_n    = 1'b1;
            nxt_s.oe_n     = 1'b1;
            nxt_s.we_n     = 1'b1;
            nxt_s.hw_reset = 1'b1;
        end
    end

    // State register
    always_ff @(posedge i_clock) begin
        s_ff <= nxt_s;
    end

    // Socket drive; data only while a write is in progress
    assign bus.ce1_n      = s_ff.ce1_n;
    assign bus.ce2_n      = s_ff.ce2_n;
    assign bus.reg_n      = s_ff.reg_n;
    assign bus.oe_n       = s_ff.oe_n;
    assign bus.we_n       = s_ff.we_n;
    assign bus.addr       = s_ff.addr;
    assign bus.card_reset = s_ff.hw_reset;
    assign bus.host_d     = s_ff.wdata;
    assign bus.host_d_oe  = s_ff.write && (s_ff.st == ST_SETUP || s_ff.st == ST_STROBE);

    // Command answers
    assign o_ready = (s_ff.st == ST_IDLE) && (s_ff.sr_phase == 2'd0);
    assign o_done  = s_ff.done;
    assign o_rdata = s_ff.rdata;

endmodule // card_socket_host

// >>> bench/card_socket_checker.sv
// Pin-level checks between the host end and the card end.
// Assumes every pin is sampled on i_clock and comes up released after i_rst.
module card_socket_checker (
    // Clock and reset
    input wire logic        i_clock,
    input wire logic        i_rst,
    // Socket pins
    input wire logic        ce1_n,
    input wire logic        ce2_n,
    input wire logic        reg_n,
    input wire logic        oe_n,
    input wire logic        we_n,
    input wire logic [10:0] addr,
    input wire logic        card_reset,
    input wire logic [15:0] host_d,
    input wire logic        host_d_oe,
    input wire logic [15:0] card_d,
    input wire logic        card_d_oe_lo,
    input wire logic        card_d_oe_hi,
    input wire logic [15:0] data
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // Decoded spaces; soft reset is invisible here, so reads are kept out of it
    logic cfg_sel, cis_sel, lo_sel, hi_sel, wd_sel;
    assign cfg_sel = !reg_n && !ce1_n && addr[10:9] == 2'h1 && addr[8:3] == 6'h00 && !addr[0];
    assign cis_sel = !reg_n && !ce1_n && ce2_n && addr[10:9] == 2'h0 && !addr[0];
    assign lo_sel  = reg_n && !ce1_n && ce2_n;
    assign hi_sel  = reg_n && ce1_n && !ce2_n;
    assign wd_sel  = reg_n && !ce1_n && !ce2_n && !addr[0];

    // Read strobe opens on a selected space and is still held a cycle later
    sequence rd_at(sel);
        $fell(oe_n) && we_n && !card_reset && sel ##1 !oe_n;
    endsequence

    AST_IDLE_HIZ: assert property (ce1_n && ce2_n |-> !card_d_oe_lo && !card_d_oe_hi)
        else $error("card drives data while deselected");
    AST_NO_DRIVE_WR: assert property (!we_n |-> !card_d_oe_lo && !card_d_oe_hi)
        else $error("card drives data during a write strobe");
    AST_STROBE_EXCL: assert property (!(!oe_n && !we_n))
        else $error("read and write strobes low together");
    AST_ATTR_HI_OFF: assert property (!reg_n |-> !card_d_oe_hi)
        else $error("attribute access drives high lane");
    AST_CE2_ATTR: assert property (!reg_n && ce1_n |-> !card_d_oe_lo)
        else $error("high-only attribute access answered");
    AST_ODD_ATTR: assert property (!reg_n && ce2_n && addr[0] |-> !card_d_oe_lo)
        else $error("odd attribute access answered");
    AST_CFG_READ: assert property (rd_at(cfg_sel) |-> card_d_oe_lo)
        else $error("configuration read not answered on low lane");
    AST_CIS_READ: assert property (rd_at(cis_sel) |-> card_d_oe_lo)
        else $error("identification read not answered");
    AST_LO_LANE: assert property (rd_at(lo_sel) |-> card_d_oe_lo && !card_d_oe_hi)
        else $error("low byte read on wrong lane");
    AST_HI_LANE: assert property (rd_at(hi_sel) |-> card_d_oe_hi && !card_d_oe_lo)
        else $error("high byte read on wrong lane");
    AST_WORD: assert property (rd_at(wd_sel) |-> card_d_oe_hi && card_d_oe_lo)
        else $error("word read not on both lanes");
endmodule // card_socket_checker

// >>> bench/card_attribute_space_decoder_tb_top.sv
// Bench joining host end and card end through the socket interface.
// Assumes host command port rules of the hand-over; memory and CIS are bench models.
module card_attribute_space_decoder_tb_top;
    import card_attr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed { logic [1:0] m; logic [15:0] v; } note_type;
    logic i_clock, i_rst, i_req, i_write, i_attr, i_word, i_hi_lane, i_soft_reset, i_hw_reset;
    logic [10:0] i_addr, mem_addr;
    logic [15:0] i_wdata, o_rdata, mem_wdata, last_wd;
    logic o_ready, o_done, mem_wr, card_rst, hard_rst, irq_lvl;
    logic [1:0]  mem_lane, last_lane;
    logic [5:0]  cfg_idx;
    logic [10:0] last_addr;
    map_mode_type map_mode;
    note_type notes[$];
    int err_count = 0, checked = 0, wr_seen = 0, hr_cycles = 0;

    card_socket_if sock ();
    // Bench memory and identification contents follow the live address
    wire [15:0] mem_rdata = {~sock.addr[7:0], sock.addr[7:0]};
    wire [7:0]  cis_rdata = sock.addr[8:1] ^ 8'h3C;

    card_attr_decoder i_card_attr_decoder (.i_clock, .i_rst, .bus(sock), .o_mem_rd(),
        .o_mem_wr(mem_wr), .o_mem_addr(mem_addr), .o_mem_lane(mem_lane),
        .o_mem_wdata(mem_wdata), .i_mem_rdata(mem_rdata), .o_cis_rd(), .i_cis_rdata(cis_rdata),
        .o_card_reset(card_rst), .o_hard_reset(hard_rst), .o_irq_level(irq_lvl),
        .o_config_index(cfg_idx), .o_map_mode(map_mode));
    card_socket_host i_card_socket_host (.i_clock, .i_rst, .bus(sock), .i_req, .i_write,
        .i_attr, .i_word, .i_hi_lane, .i_addr, .i_wdata, .i_soft_reset, .i_hw_reset,
        .o_ready, .o_done, .o_rdata);
    card_socket_checker i_card_socket_checker (.i_clock, .i_rst, .ce1_n(sock.ce1_n),
        .ce2_n(sock.ce2_n), .reg_n(sock.reg_n), .oe_n(sock.oe_n), .we_n(sock.we_n),
        .addr(sock.addr), .card_reset(sock.card_reset), .host_d(sock.host_d),
        .host_d_oe(sock.host_d_oe), .card_d(sock.card_d), .card_d_oe_lo(sock.card_d_oe_lo),
        .card_d_oe_hi(sock.card_d_oe_hi), .data(sock.data));

    initial begin
        i_clock = 1'h0;
        forever #5 i_clock = ~i_clock;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude;
        if (err_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // One command; lane mask m says which bytes of the answer are compared
    task automatic op(input logic w, a, wd, h, input logic [10:0] ad, input logic [15:0] d,
                      input logic [1:0] m, input logic [15:0] v);
        int n;
        n = 0;
        @(negedge i_clock);
        while (o_ready !== 1'h1 && n < 300) begin
            @(negedge i_clock);
            n++;
        end
        {i_write, i_attr, i_word, i_hi_lane, i_addr, i_wdata} = {w, a, wd, h, ad, d};
        i_req = 1'h1;
        notes.push_back('{m, v});
        @(negedge i_clock);
        i_req = 1'h0;
    endtask

    // Wait out all commands, then let register updates land
    task automatic drain;
        int n;
        n = 0;
        while (notes.size() != 0 && n < 500) begin
            @(negedge i_clock);
            n++;
        end
        repeat (2) @(negedge i_clock);
    endtask

    // Result watcher, memory write and reset monitors
    always @(posedge i_clock) begin
        if (o_done === 1'h1 && notes.size() != 0) begin
            if (notes[0].m[0]) check("rdata_lo", o_rdata[7:0], notes[0].v[7:0]);
            if (notes[0].m[1]) check("rdata_hi", o_rdata[15:8], notes[0].v[15:8]);
            void'(notes.pop_front());
        end
        if (mem_wr === 1'h1) begin
            wr_seen++;
            {last_lane, last_addr, last_wd} = {mem_lane, mem_addr, mem_wdata};
        end
        if (hard_rst === 1'h1) hr_cycles++;
    end

    initial begin
        #100us;
        err_count++;
        conclude();
    end

    initial begin
        logic [15:0] r, d, opt, lm;
        logic [10:0] a;
        logic [1:0]  m;
        logic [7:0]  wm;
        int k, w0;
        {i_req, i_write, i_attr, i_word, i_hi_lane, i_addr, i_wdata} = '0;
        {i_soft_reset, i_hw_reset, i_rst} = 3'h1;
        r = 16'($urandom(32'h087CED4B));
        repeat (5) @(negedge i_clock);
        i_rst = 1'h0;
        // Option register and mapping after reset
        op(1'h0, 1'h1, 1'h0, 1'h0, 11'h200, 16'h0, 2'h1, 16'h0);
        drain();
        check("map", map_mode, MAP_MEMORY);
        // Every mapping index, random interrupt mode, reserved bits forced clear
        for (k = 0; k < 4; k++) begin
            r = 16'($urandom);
            d = {9'h0, r[0], r[2:1], 2'h0, k[1:0]};
            opt = {8'h0, d[7:6], 4'h0, k[1:0]};
            op(1'h1, 1'h1, 1'h0, 1'h0, 11'h200, d, 2'h0, 16'h0);
            op(1'h0, 1'h1, 1'h0, 1'h0, 11'h200, 16'h0, 2'h1, opt);
            drain();
            check("index", cfg_idx, k);
            check("map", map_mode, 16'h1 << k);
            check("irq", irq_lvl, r[0]);
        end
        // Remaining configuration registers keep their writable bits
        for (k = 1; k < 4; k++) begin
            r = 16'($urandom);
            wm = (k == 1) ? STATUS_WMASK : (k == 2) ? PINREP_WMASK : SOCKET_WMASK;
            a = 11'(11'h200 + 2 * k);
            op(1'h1, 1'h1, 1'h0, 1'h0, a, r, 2'h0, 16'h0);
            op(1'h0, 1'h1, 1'h0, 1'h0, a, 16'h0, 2'h1, {8'h0, r[7:0] & wm});
        end
        // Word, odd and high-only attribute asks; host folds them to even low-lane bytes
        op(1'h0, 1'h1, 1'h1, 1'h0, 11'h200, 16'h0, 2'h3, {8'hFF, opt[7:0]});
        op(1'h0, 1'h1, 1'h0, 1'h0, 11'h201, 16'h0, 2'h1, opt);
        op(1'h1, 1'h1, 1'h0, 1'h0, 11'h201, opt, 2'h0, 16'h0);
        op(1'h1, 1'h1, 1'h0, 1'h1, 11'h200, opt, 2'h0, 16'h0);
        op(1'h0, 1'h1, 1'h0, 1'h1, 11'h200, 16'h0, 2'h2, 16'hFF00);
        op(1'h0, 1'h1, 1'h0, 1'h0, 11'h200, 16'h0, 2'h1, opt);
        // Identification space reads, writes leave everything alone
        a = 11'($urandom) & 11'h1FE;
        w0 = wr_seen;
        op(1'h0, 1'h1, 1'h0, 1'h0, a, 16'h0, 2'h1, {8'h0, a[8:1] ^ 8'h3C});
        op(1'h1, 1'h1, 1'h0, 1'h0, a, 16'h0041, 2'h0, 16'h0);
        op(1'h0, 1'h1, 1'h0, 1'h0, 11'h200, 16'h0, 2'h1, opt);
        drain();
        check("memwr", wr_seen, w0);
        // Common memory: low byte, high byte, word
        for (k = 0; k < 3; k++) begin
            a = 11'($urandom) & ~11'(k == 2);
            d = 16'($urandom);
            m = (k == 0) ? 2'h1 : (k == 1) ? 2'h2 : 2'h3;
            lm = {{8{m[1]}}, {8{m[0]}}};
            op(1'h1, 1'h0, k == 2, k == 1, a, d, 2'h0, 16'h0);
            op(1'h0, 1'h0, k == 2, k == 1, a, 16'h0, m, {~a[7:0], a[7:0]});
            drain();
            check("lane", last_lane, m);
            check("waddr", last_addr, a);
            check("wdata", last_wd & lm, d & lm);
        end
        // Soft reset sequence clears a configured card
        op(1'h1, 1'h1, 1'h0, 1'h0, 11'h200, 16'h0042, 2'h0, 16'h0);
        drain();
        hr_cycles = 0;
        i_soft_reset = 1'h1;
        notes.push_back('{2'h0, 16'h0});
        @(negedge i_clock);
        i_soft_reset = 1'h0;
        drain();
        check("hold", hr_cycles >= RESET_CYCLES, 1'h1);
        check("unconf", {card_rst, irq_lvl, cfg_idx}, 16'h0);
        op(1'h0, 1'h1, 1'h0, 1'h0, 11'h200, 16'h0, 2'h1, 16'h0);
        // Hardware reset pin clears option register
        op(1'h1, 1'h1, 1'h0, 1'h0, 11'h200, 16'h0041, 2'h0, 16'h0);
        drain();
        i_hw_reset = 1'h1;
        repeat (3) @(negedge i_clock);
        check("hwrst", {card_rst, hard_rst}, 16'h3);
        i_hw_reset = 1'h0;
        repeat (3) @(negedge i_clock);
        op(1'h0, 1'h1, 1'h0, 1'h0, 11'h200, 16'h0, 2'h1, 16'h0);
        drain();
        conclude();
    end
endmodule // card_attribute_space_decoder_tb_top
